//--- verilog/sesf_top.sv
// Purpose: Sync edge sense flags, bank select and shared timer window over AHB-Lite
// Assumes: Pin inputs synchronous to clk; OKAY response always
// Notes: Window slots 6 and 7 of the second bank read zero and ignore writes
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
module sesf_top
  import sesf_pkg::*;
(
  input  wire logic        clk,                // System clock, 25 MHz
  input  wire logic        rst,                // Synchronous reset, active high
  input  wire logic        hsel,               // Slave select
  input  wire logic [31:0] haddr,              // Byte address
  input  wire logic [1:0]  htrans,             // Transfer type
  input  wire logic        hwrite,             // Write when high
  input  wire logic [2:0]  hsize,              // Transfer size
  input  wire logic        hready,             // Bus ready in
  input  wire logic [31:0] hwdata,             // Write data
  output logic      [31:0] hrdata,             // Read data
  output logic             hreadyout,          // Slave ready
  output logic             hresp,              // Response, always OKAY
  input  wire logic        vert_sync_pin,      // Vertical sync input
  input  wire logic        horiz_sync_pin,     // Horizontal sync input
  input  wire logic        composite_sync_pin, // Composite sync input
  input  wire logic        horiz_flyback_pin,  // Horizontal flyback input
  input  wire logic        vert_flyback_pin,   // Vertical flyback input
  input  wire logic        internal_horiz_in,  // Routed horizontal signal
  input  wire logic        internal_vert_in,   // Routed vertical signal
  input  wire logic        mask_interval,      // High during the half-line mask
  output logic             timer_bank_select,  // Window steering bit
  output logic             irq                 // Level interrupt
);
  sesf_state_e state_reg;
  sesf_state_e state_next;
  logic [7:0]  addr_reg;
  logic [5:0]  flag_reg;
  logic [5:0]  seen_reg;
  logic [4:0]  pin_reg;
  logic        ihi_reg;
  logic [7:0]  conn_reg;
  logic [5:0]  istat_reg;
  logic [5:0]  ien_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  win_rdata;

  wire         take      = hsel && hready && htrans[1];
  wire [4:0]   pins      = {vert_sync_pin, horiz_sync_pin, composite_sync_pin,
                            horiz_flyback_pin, vert_flyback_pin};
  wire [4:0]   pin_rise  = pins & ~pin_reg;
  wire         ihi_edge  = (internal_horiz_in ^ ihi_reg) && mask_interval;
  wire [5:0]   set_ev    = {pin_rise, ihi_edge};
  wire         is_wr     = (state_reg == SESF_ST_WRITE);
  wire         is_rd     = (state_reg == SESF_ST_READ);
  wire         wr_edge   = is_wr && (addr_reg == SESF_OFF_EDGE);
  wire         rd_edge   = is_rd && (addr_reg == SESF_OFF_EDGE);
  wire         in_win    = (addr_reg[7:5] == SESF_OFF_WIN[7:5]);
  wire [2:0]   win_slot  = addr_reg[4:2];
  wire         win_hole  = conn_reg[SESF_BIT_BANK] && win_slot[2] && win_slot[1];
  wire [7:0]   edge_word = {flag_reg, internal_horiz_in, internal_vert_in};
  // Cleared only where a 0 is written to a bit seen as 1
  wire [5:0]   clr_ok    = wr_edge ? (seen_reg & ~hwdata[7:2]) : 6'h00;
  wire [5:0]   flag_next = (flag_reg & ~clr_ok) | set_ev;
  wire         mem_we    = is_wr && in_win && !win_hole;
  wire [3:0]   mem_addr  = {conn_reg[SESF_BIT_BANK], is_wr || is_rd ? win_slot : haddr[4:2]};

  sesf_win_mem u_win (
    .clk   (clk),
    .rst   (rst),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (hwdata[7:0]),
    .rdata (win_rdata)
  );

  always_comb
  begin
    state_next = SESF_ST_IDLE;
    case (state_reg)
      SESF_ST_IDLE, SESF_ST_WRITE, SESF_ST_READ:
        if (take)
          state_next = hwrite ? SESF_ST_WRITE : SESF_ST_READ;
      default:
        state_next = SESF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= SESF_ST_IDLE;
      addr_reg  <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      if (take)
        addr_reg <= haddr[7:0];
    end
  end

  // Window reads need the address early, so the memory sees haddr during an address phase taken from SESF_ST_IDLE
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_reg  <= SESF_FLAG_RST;
      seen_reg  <= SESF_FLAG_RST;
      pin_reg   <= 5'h1F;
      ihi_reg   <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      pin_reg  <= pins;
      ihi_reg  <= internal_horiz_in;
      if (rd_edge)
        seen_reg <= flag_reg;
      else if (wr_edge)
        seen_reg <= 6'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conn_reg  <= SESF_CONN_RST;
      ien_reg   <= 6'h00;
      mask_reg  <= SESF_MASK_RST;
      istat_reg <= 6'h00;
    end
    else
    begin
      if (is_wr && addr_reg == SESF_OFF_CONN)
        conn_reg <= hwdata[7:0];
      if (is_wr && addr_reg == SESF_OFF_IEN)
        ien_reg <= hwdata[5:0];
      if (is_wr && addr_reg == SESF_OFF_MASK)
        mask_reg <= hwdata[7:0];
      // New events win over a clear in the same cycle
      istat_reg <= (istat_reg & ~((is_wr && addr_reg == SESF_OFF_ICLR) ? hwdata[5:0] : 6'h00))
                   | set_ev;
    end
  end

  wire [7:0] rd_mux =
    (addr_reg == SESF_OFF_EDGE)  ? edge_word :
    (addr_reg == SESF_OFF_CONN)  ? conn_reg :
    (addr_reg == SESF_OFF_ISTAT) ? {2'b00, istat_reg} :
    (addr_reg == SESF_OFF_IEN)   ? {2'b00, ien_reg} :
    (addr_reg == SESF_OFF_MASK)  ? mask_reg :
    (in_win && !win_hole)        ? win_rdata : 8'h00;

  assign hrdata            = is_rd ? {24'h000000, rd_mux} : 32'h00000000;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign timer_bank_select = conn_reg[SESF_BIT_BANK];
  assign irq               = |(istat_reg & ien_reg);

  a_flag_reset: assert property (@(posedge clk) rst |=> flag_reg == 6'h00)
    else $error("flags not zero after reset");
  a_vedge_set: assert property (@(posedge clk) disable iff (rst)
    $rose(vert_sync_pin) |=> flag_reg[5])
    else $error("vertical sync edge missed");
  a_hedge_set: assert property (@(posedge clk) disable iff (rst)
    $rose(horiz_sync_pin) |=> flag_reg[4])
    else $error("horizontal sync edge missed");
  a_cedge_set: assert property (@(posedge clk) disable iff (rst)
    $rose(composite_sync_pin) |=> flag_reg[3])
    else $error("composite sync edge missed");
  a_hfb_set: assert property (@(posedge clk) disable iff (rst)
    $rose(horiz_flyback_pin) |=> flag_reg[2])
    else $error("horizontal flyback edge missed");
  a_vfb_set: assert property (@(posedge clk) disable iff (rst)
    $rose(vert_flyback_pin) |=> flag_reg[1])
    else $error("vertical flyback edge missed");
  a_preq_set: assert property (@(posedge clk) disable iff (rst)
    mask_interval && (internal_horiz_in != ihi_reg) |=> flag_reg[0])
    else $error("pre-equalization edge missed");
  a_clear_needs_read: assert property (@(posedge clk) disable iff (rst)
    (|(flag_reg & ~$past(flag_reg)) == 1'b0) && $fell(flag_reg[5]) |-> $past(seen_reg[5]))
    else $error("flag cleared without prior read");
  a_level_bits: assert property (@(posedge clk) disable iff (rst)
    is_rd && addr_reg == SESF_OFF_EDGE |-> hrdata[1:0] == {internal_horiz_in, internal_vert_in})
    else $error("level bits wrong");
  a_bank_write: assert property (@(posedge clk) disable iff (rst)
    is_wr && addr_reg == SESF_OFF_CONN |=> timer_bank_select == $past(hwdata[7]))
    else $error("bank select not stored");
  a_hole_zero: assert property (@(posedge clk) disable iff (rst)
    is_rd && in_win && win_hole |-> hrdata == 32'h0)
    else $error("unused slot not zero");

  c_edge_read: cover property (@(posedge clk) rd_edge && flag_reg != 6'h00);
  c_flag_clear: cover property (@(posedge clk) wr_edge && clr_ok != 6'h00);
  c_bank_one: cover property (@(posedge clk) mem_we && conn_reg[SESF_BIT_BANK]);
  c_irq: cover property (@(posedge clk) irq);
endmodule

//--- verilog/sesf_pkg.sv
// Purpose: Constants for the sync edge sense flag block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Offsets, field positions and reset values of the register map
package sesf_pkg;
  localparam logic [7:0] SESF_OFF_EDGE   = 8'h00;
  localparam logic [7:0] SESF_OFF_CONN   = 8'h04;
  localparam logic [7:0] SESF_OFF_ISTAT  = 8'h08;
  localparam logic [7:0] SESF_OFF_IEN    = 8'h0C;
  localparam logic [7:0] SESF_OFF_ICLR   = 8'h10;
  localparam logic [7:0] SESF_OFF_MASK   = 8'h14;
  localparam logic [7:0] SESF_OFF_WIN    = 8'h20;
  localparam int         SESF_BIT_BANK   = 7;
  localparam int         SESF_BIT_IHI    = 1;
  localparam int         SESF_BIT_IVI    = 0;
  localparam int         SESF_NFLAG      = 6;
  localparam logic [7:0] SESF_CONN_RST   = 8'h00;
  localparam logic [5:0] SESF_FLAG_RST   = 6'h00;
  localparam logic [7:0] SESF_MASK_RST   = 8'h00;
  localparam logic [3:0] SESF_WIN_WORDS  = 4'h8;
  localparam logic [3:0] SESF_WIN_ABITS  = 4'h3;
  typedef enum logic [2:0] {
    SESF_ST_IDLE  = 3'b001,
    SESF_ST_WRITE = 3'b010,
    SESF_ST_READ  = 3'b100
  } sesf_state_e;
endpackage

//--- verilog/sesf_win_mem.sv
// Purpose: Storage behind the shared timer window, sixteen byte registers
// Assumes: One write or read per cycle, read data registered
// Notes: Bank select forms the top address bit
module sesf_win_mem
  import sesf_pkg::*;
(
  input  wire logic       clk,   // System clock
  input  wire logic       rst,   // Synchronous reset
  input  wire logic       we,    // Write strobe
  input  wire logic [3:0] addr,  // Bank and slot
  input  wire logic [7:0] wdata, // Write data
  output logic      [7:0] rdata  // Registered read data
);
  logic [7:0] mem_reg [16];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        mem_reg[i] <= 8'h00;
      rdata <= 8'h00;
    end
    else
    begin
      if (we)
        mem_reg[addr] <= wdata;
      rdata <= mem_reg[addr];
    end
  end
endmodule

//--- tb/sesf_sync_src.sv
// Purpose: Video sync source driving the edge sense pins and the routed levels
// Assumes: Bench asks for levels; they reach the pins one clock later
// Notes: Registered, so every pin edge lands just after a clock edge
module sesf_sync_src
(
  input  wire logic       clk,     // System clock
  input  wire logic [7:0] lvl_cmd, // Asked levels: pins 7:3, horiz, vert, mask
  output logic      [7:0] lvl_out  // Driven levels, same order
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk)
  begin
    lvl_out <= lvl_cmd;
  end
endmodule

//--- tb/sync_edge_sense_flags_tb.sv
// Purpose: Self-checking bench for the sync edge sense flag block
// Assumes: Zero wait state slave; hready is fed from hreadyout
// Notes: Pin moves are given three clocks to reach the flags
module sync_edge_sense_flags_tb;
  import sesf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hresp, hreadyout, bank, irq;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  cmd, lvl, f, o;
  logic [7:0]  m [2][8];
  int          err_count, checks, i, b;
  sesf_sync_src i_src (.clk(clk), .lvl_cmd(cmd), .lvl_out(lvl));
  sesf_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .vert_sync_pin(lvl[7]), .horiz_sync_pin(lvl[6]),
    .composite_sync_pin(lvl[5]), .horiz_flyback_pin(lvl[4]), .vert_flyback_pin(lvl[3]),
    .internal_horiz_in(lvl[2]), .internal_vert_in(lvl[1]), .mask_interval(lvl[0]),
    .timer_bank_select(bank), .irq(irq));
  always #20 clk = ~clk;
  function automatic logic [7:0] nxt_flags(logic [7:0] fl, logic [7:0] ov, logic [7:0] nv);
    return fl | {nv[7:3] & ~ov[7:3], (nv[2] ^ ov[2]) & nv[0] & ov[0], 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Ready and read data are taken at the rising edge, before that edge's updates land
  task automatic wait_rdy(output logic [31:0] d);
    logic rdy;
    rdy = 1'b0;
    for (int n = 0; n < 20 && rdy !== 1'b1; n++)
    begin
      @(posedge clk);
      rdy = hreadyout;
      d = hrdata;
    end
    if (rdy !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic [31:0] d;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask
  task automatic drive(input logic [7:0] nv);
    cmd <= nv;
    repeat (3) @(posedge clk);
    f = nxt_flags(f, o, nv);
    o = nv;
  endtask
  task automatic edge_chk();
    rdc("edge word", SESF_OFF_EDGE, {24'h0, f[7:2], o[2:1]});
  endtask
  initial
  begin
    seed = 32'h9EFD2D2F;
    {clk, rst, hsel, hwrite, htrans, haddr, hwdata, cmd, f, o} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    err_count = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    edge_chk();
    rdc("conn", SESF_OFF_CONN, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      drive({r[7:1], 1'b0});
      edge_chk();
      wr(SESF_OFF_EDGE, 32'h0);
      f = 8'h00;
    end
    $display("test random edges done");
    drive(o & 8'h7E);
    drive(o | 8'h80);
    wr(SESF_OFF_EDGE, 32'h0);
    edge_chk();
    wr(SESF_OFF_EDGE, 32'hFF);
    edge_chk();
    wr(SESF_OFF_EDGE, 32'h0);
    f = 8'h00;
    edge_chk();
    drive(o | 8'h01);
    drive(o ^ 8'h04);
    edge_chk();
    wr(SESF_OFF_EDGE, 32'h0);
    f = 8'h00;
    drive(o & 8'hFE);
    drive(o ^ 8'h04);
    edge_chk();
    $display("test flag clear done");
    wr(SESF_OFF_ICLR, 32'h3F);
    wr(SESF_OFF_IEN, 32'h20);
    drive(o & 8'h7F);
    rdc("istat clear", SESF_OFF_ISTAT, 32'h0);
    drive(o | 8'h80);
    rdc("istat", SESF_OFF_ISTAT, 32'h20);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(SESF_OFF_IEN, 32'h0);
    // Register outputs are looked at mid-cycle, after the edge that updates them
    @(negedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(SESF_OFF_IEN, 32'h20);
    wr(SESF_OFF_ICLR, 32'h20);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rdc("istat cleared", SESF_OFF_ISTAT, 32'h0);
    $display("test interrupt done");
    for (b = 0; b < 2; b++)
    begin
      wr(SESF_OFF_CONN, {24'h0, b[0], 7'h00});
      @(negedge clk);
      chk("bank", {31'h0, bank}, 32'(b));
      for (i = 0; i < 8; i++)
      begin
        m[b][i] = 8'($random(seed));
        wr(SESF_OFF_WIN + 8'(4 * i), {24'hFFFFFF, m[b][i]});
        if (b == 1 && i > 5)
          m[b][i] = 8'h00;
      end
    end
    rdc("conn bank", SESF_OFF_CONN, 32'h80);
    for (b = 1; b >= 0; b--)
    begin
      wr(SESF_OFF_CONN, {24'h0, b[0], 7'h00});
      for (i = 0; i < 8; i++)
        rdc("window", SESF_OFF_WIN + 8'(4 * i), {24'h0, m[b][i]});
    end
    rdc("unmapped", 8'h40, 32'h0);
    $display("test window done");
    summarize();
  end
endmodule
